// [rtl/step_dir_params.svh]
// constants for the step/direction microstep control block
`ifndef STEP_DIR_PARAMS_SVH
`define STEP_DIR_PARAMS_SVH
`define WORD_BITS       5'h14
`define WORD_MSB        5'h13
`define CMD_HI          19
`define CMD_LO          18
`define CFG_STEP_BOTH_EDGES_SEL_BIT   0
`define CFG_DISABLE_BIT 1
`define CFG_CHOP_BIT    2
`define CFG_MRES_LO     4
`define CFG_MRES_HI     7
`define COIL_SIGN_BIT   8
`define COIL_MAG_HI     7
`define MRES_RESET      4'h0
`define MRES_MAX        4'h8
`define QUARTER_STEPS   10'h100
`define DEGLITCH_NS     60
`define CORE_CLK_MHZ    200
`define DEGLITCH_CYC    ((`DEGLITCH_NS * `CORE_CLK_MHZ + 999) / 1000)
`endif

// [rtl/step_dir_pkg.sv]
// types shared by the step/direction microstep control block
package step_dir_pkg;
	typedef enum logic [1:0] {
		CMD_CONFIG   = 2'b00,
		CMD_COIL_A   = 2'b01,
		CMD_COIL_B   = 2'b10,
		CMD_RESERVED = 2'b11
	} cmd_e;
	typedef enum logic {
		CHOP_OFF_TIME   = 1'b0,
		CHOP_HYSTERESIS = 1'b1
	} chop_e;
	typedef logic [19:0] word_t;
	typedef logic [9:0]  ustep_t;
endpackage : step_dir_pkg

// [rtl/spi_link_if.sv]
// carrier between the serial word slave and the core logic
interface spi_link_if;
	step_dir_pkg::word_t cmd_word;
	logic                cmd_toggle;
	step_dir_pkg::word_t status_word;
	modport link (output cmd_word, output cmd_toggle, input status_word);
	modport core (input cmd_word, input cmd_toggle, output status_word);
endinterface : spi_link_if

// [rtl/input_deglitch.sv]
// two-stage synchroniser followed by a minimum-width pulse filter
`include "step_dir_params.svh"

module input_deglitch (
	input  wire logic core_clk_i,
	input  wire logic rstn_i,
	input  wire logic pin_i,
	output logic      level_o
);
	localparam logic [3:0] HOLD = 4'(`DEGLITCH_CYC - 1);
	logic       sync1_ff;
	logic       sync2_ff;
	logic [3:0] stable_cnt_ff;

	// bring the pin into the core domain
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
		end else begin
			sync1_ff <= pin_i;
			sync2_ff <= sync1_ff;
		end
	end

	// a new level is taken only after it held for the full filter time
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stable_cnt_ff <= 4'h0;
			level_o       <= 1'b0;
		end else if (sync2_ff == level_o) begin
			stable_cnt_ff <= 4'h0;
		end else if (stable_cnt_ff == HOLD) begin
			stable_cnt_ff <= 4'h0;
			level_o       <= sync2_ff;
		end else begin
			stable_cnt_ff <= stable_cnt_ff + 4'h1;
		end
	end
endmodule : input_deglitch

// [rtl/spi_word_slave.sv]
// serial slave on the bus clock: one 20-bit word in, one 20-bit word out
`include "step_dir_params.svh"

module spi_word_slave (
	input  wire logic spi_sck_i,
	input  wire logic spi_csn_i,
	input  wire logic spi_sdi_i,
	input  wire logic rstn_i,
	output logic      spi_sdo_o,
	output logic      spi_sdo_oe_o,
	spi_link_if.link  lnk
);
	logic [18:0] shift_ff;
	logic [4:0]  rx_cnt_ff;
	logic [4:0]  tx_cnt_ff;

	// receive on rising edge; bits after the twentieth are ignored
	always_ff @(posedge spi_sck_i or posedge spi_csn_i) begin
		if (spi_csn_i) begin
			shift_ff  <= 19'h00000;
			rx_cnt_ff <= 5'h00;
		end else if (rx_cnt_ff != `WORD_BITS) begin
			shift_ff  <= {shift_ff[17:0], spi_sdi_i};
			rx_cnt_ff <= rx_cnt_ff + 5'h01;
		end
	end

	// hand the complete word over with a toggle
	always_ff @(posedge spi_sck_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lnk.cmd_word   <= 20'h00000;
			lnk.cmd_toggle <= 1'b0;
		end else if (rx_cnt_ff == `WORD_MSB) begin
			lnk.cmd_word   <= {shift_ff, spi_sdi_i};
			lnk.cmd_toggle <= ~lnk.cmd_toggle;
		end
	end

	// transmit on falling edge, msb first, one bit per received bit
	always_ff @(negedge spi_sck_i or posedge spi_csn_i) begin
		if (spi_csn_i) begin
			tx_cnt_ff    <= 5'h00;
			spi_sdo_o    <= 1'b0;
			spi_sdo_oe_o <= 1'b0;
		end else if (tx_cnt_ff != `WORD_BITS) begin
			spi_sdo_oe_o <= 1'b1;
			spi_sdo_o    <= lnk.status_word[`WORD_MSB - tx_cnt_ff];
			tx_cnt_ff    <= tx_cnt_ff + 5'h01;
		end else begin
			spi_sdo_o    <= 1'b0;
		end
	end
endmodule : spi_word_slave

// [rtl/step_dir_microstep_control.sv]
// top of the step/direction microstep control front end
`include "step_dir_params.svh"

module step_dir_microstep_control (
	input  wire logic  core_clk_i,
	input  wire logic  rstn_i,
	input  wire logic  spi_sck_i,
	input  wire logic  spi_csn_i,
	input  wire logic  spi_sdi_i,
	output logic       spi_sdo_o,
	output logic       spi_sdo_oe_o,
	input  wire logic  step_i,
	input  wire logic  dir_i,
	output logic [7:0] coil_a_mag_o,
	output logic       coil_a_neg_o,
	output logic [7:0] coil_b_mag_o,
	output logic       coil_b_neg_o,
	output logic       chop_mode_o,
	output logic       step_dir_en_o,
	output logic [9:0] ustep_count_o
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	spi_link_if link_bus ();

	logic                        csn_sync1_ff;
	logic                        csn_sync2_ff;
	logic                        tog_sync1_ff;
	logic                        tog_sync2_ff;
	logic                        tog_seen_ff;
	logic                        cmd_strobe;
	step_dir_pkg::cmd_e          cmd_kind;
	step_dir_pkg::word_t         cmd_word;

	logic                        step_both_edges_sel_ff;
	logic                        step_dir_dis_ff;
	step_dir_pkg::chop_e         chop_mode_ff;
	logic [3:0]                  mres_ff;
	logic [3:0]                  nxt_mres;

	logic [7:0]                  direct_a_mag_ff;
	logic                        direct_a_neg_ff;
	logic [7:0]                  direct_b_mag_ff;
	logic                        direct_b_neg_ff;

	logic                        step_flt;
	logic                        dir_flt;
	logic                        step_prev_ff;
	logic                        step_rise;
	logic                        step_fall;
	logic                        step_evt;

	step_dir_pkg::ustep_t        ustep_ff;
	step_dir_pkg::ustep_t        nxt_ustep;
	step_dir_pkg::ustep_t        step_size;
	logic [8:0]                  sine_val;
	logic [8:0]                  cosine_val;

	step_dir_pkg::word_t         status_ff;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------

	// quarter-wave sine at 33 points, full scale 255
	function automatic logic [7:0] sine_table(input logic [5:0] idx);
		logic [7:0] val;
		val = 8'hff;
		case (idx)
			6'h00: val = 8'h00;
			6'h01: val = 8'h0d;
			6'h02: val = 8'h19;
			6'h03: val = 8'h25;
			6'h04: val = 8'h32;
			6'h05: val = 8'h3e;
			6'h06: val = 8'h4a;
			6'h07: val = 8'h56;
			6'h08: val = 8'h62;
			6'h09: val = 8'h6d;
			6'h0a: val = 8'h78;
			6'h0b: val = 8'h83;
			6'h0c: val = 8'h8e;
			6'h0d: val = 8'h98;
			6'h0e: val = 8'ha2;
			6'h0f: val = 8'hab;
			6'h10: val = 8'hb4;
			6'h11: val = 8'hbd;
			6'h12: val = 8'hc5;
			6'h13: val = 8'hcd;
			6'h14: val = 8'hd4;
			6'h15: val = 8'hdb;
			6'h16: val = 8'he1;
			6'h17: val = 8'he7;
			6'h18: val = 8'hec;
			6'h19: val = 8'hf0;
			6'h1a: val = 8'hf4;
			6'h1b: val = 8'hf7;
			6'h1c: val = 8'hfa;
			6'h1d: val = 8'hfc;
			6'h1e: val = 8'hfe;
			6'h1f: val = 8'hff;
			default: val = 8'hff;
		endcase
		return val;
	endfunction : sine_table

	// linear interpolation between table points, pos runs 0..256
	function automatic logic [7:0] quarter_sine(input logic [8:0] pos);
		logic [7:0]  lo;
		logic [7:0]  hi;
		logic [10:0] prod;
		lo   = sine_table(pos[8:3]);
		hi   = sine_table(pos[8:3] + 6'h01);
		prod = {3'h0, hi - lo} * {8'h00, pos[2:0]};
		return lo + prod[10:3];
	endfunction : quarter_sine

	// sign and magnitude of the sine at a point of the electrical period
	function automatic logic [8:0] sine_of(input step_dir_pkg::ustep_t ph);
		logic [8:0] pos;
		pos = {1'b0, ph[7:0]};
		if (ph[8]) begin
			pos = 9'h100 - {1'b0, ph[7:0]};
		end
		return {ph[9], quarter_sine(pos)};
	endfunction : sine_of

	// microsteps moved per step event for a resolution code
	function automatic step_dir_pkg::ustep_t step_of(input logic [3:0] mres);
		return step_dir_pkg::ustep_t'(10'h001 << mres);
	endfunction : step_of

	// ------------------------------------------------------------
	// serial link
	// ------------------------------------------------------------

	// word slave on the bus clock
	spi_word_slave u_spi (
		.spi_sck_i    (spi_sck_i),
		.spi_csn_i    (spi_csn_i),
		.spi_sdi_i    (spi_sdi_i),
		.rstn_i       (rstn_i),
		.spi_sdo_o    (spi_sdo_o),
		.spi_sdo_oe_o (spi_sdo_oe_o),
		.lnk          (link_bus.link)
	);

	// chip select seen in the core domain, gates status updates
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			csn_sync1_ff <= 1'b1;
			csn_sync2_ff <= 1'b1;
		end else begin
			csn_sync1_ff <= spi_csn_i;
			csn_sync2_ff <= csn_sync1_ff;
		end
	end

	// word-ready toggle crossed into the core domain
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tog_sync1_ff <= 1'b0;
			tog_sync2_ff <= 1'b0;
			tog_seen_ff  <= 1'b0;
		end else begin
			tog_sync1_ff <= link_bus.cmd_toggle;
			tog_sync2_ff <= tog_sync1_ff;
			tog_seen_ff  <= tog_sync2_ff;
		end
	end

	// word is stable here: it only changes twenty bus clocks later
	assign cmd_strobe = tog_sync2_ff ^ tog_seen_ff;
	assign cmd_word   = link_bus.cmd_word;
	assign cmd_kind   = step_dir_pkg::cmd_e'(cmd_word[`CMD_HI:`CMD_LO]);

	// ------------------------------------------------------------
	// configuration and direct currents
	// ------------------------------------------------------------

	// resolution codes above full step are clamped to full step
	always_comb begin
		nxt_mres = cmd_word[`CFG_MRES_HI:`CFG_MRES_LO];
		if (nxt_mres > `MRES_MAX) begin
			nxt_mres = `MRES_MAX;
		end
	end

	// mode bits; reset leaves step/direction active at finest resolution
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			step_both_edges_sel_ff <= 1'b0;
			step_dir_dis_ff        <= 1'b0;
			chop_mode_ff           <= step_dir_pkg::CHOP_OFF_TIME;
			mres_ff                <= `MRES_RESET;
		end else if (cmd_strobe && cmd_kind == step_dir_pkg::CMD_CONFIG) begin
			step_both_edges_sel_ff <= cmd_word[`CFG_STEP_BOTH_EDGES_SEL_BIT];
			step_dir_dis_ff        <= cmd_word[`CFG_DISABLE_BIT];
			chop_mode_ff           <= step_dir_pkg::chop_e'(cmd_word[`CFG_CHOP_BIT]);
			mres_ff                <= nxt_mres;
		end
	end

	// coil currents written straight from the controller
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			direct_a_mag_ff <= 8'h00;
			direct_a_neg_ff <= 1'b0;
			direct_b_mag_ff <= 8'h00;
			direct_b_neg_ff <= 1'b0;
		end else if (cmd_strobe) begin
			case (cmd_kind)
				step_dir_pkg::CMD_COIL_A: begin
					direct_a_mag_ff <= cmd_word[`COIL_MAG_HI:0];
					direct_a_neg_ff <= cmd_word[`COIL_SIGN_BIT];
				end
				step_dir_pkg::CMD_COIL_B: begin
					direct_b_mag_ff <= cmd_word[`COIL_MAG_HI:0];
					direct_b_neg_ff <= cmd_word[`COIL_SIGN_BIT];
				end
				default: begin
					direct_a_mag_ff <= direct_a_mag_ff;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// step and direction inputs
	// ------------------------------------------------------------

	// both pins share one filter delay, so setup to the step edge holds
	input_deglitch u_step_flt (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.pin_i      (step_i),
		.level_o    (step_flt)
	);

	input_deglitch u_dir_flt (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.pin_i      (dir_i),
		.level_o    (dir_flt)
	);

	// previous filtered step level for edge detection
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			step_prev_ff <= 1'b0;
		end else begin
			step_prev_ff <= step_flt;
		end
	end

	// active edges; ignored while the path is disabled
	assign step_rise = step_flt & ~step_prev_ff;
	assign step_fall = ~step_flt & step_prev_ff;
	assign step_evt  = (step_rise | (step_both_edges_sel_ff & step_fall)) & ~step_dir_dis_ff;

	// ------------------------------------------------------------
	// microstep counter
	// ------------------------------------------------------------

	// 10-bit counter: natural wrap covers one electrical period
	always_comb begin
		step_size = step_of(mres_ff);
		nxt_ustep = ustep_ff;
		if (step_evt) begin
			if (!dir_flt) begin
				nxt_ustep = ustep_ff + step_size;
			end else begin
				nxt_ustep = ustep_ff - step_size;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ustep_ff <= 10'h000;
		end else begin
			ustep_ff <= nxt_ustep;
		end
	end

	// ------------------------------------------------------------
	// coil current outputs
	// ------------------------------------------------------------

	// cosine leads sine by a quarter period
	assign sine_val   = sine_of(ustep_ff);
	assign cosine_val = sine_of(ustep_ff + `QUARTER_STEPS);

	// table values in step mode, written values in direct mode
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			coil_a_mag_o <= 8'h00;
			coil_a_neg_o <= 1'b0;
			coil_b_mag_o <= 8'h00;
			coil_b_neg_o <= 1'b0;
		end else if (step_dir_dis_ff) begin
			coil_a_mag_o <= direct_a_mag_ff;
			coil_a_neg_o <= direct_a_neg_ff;
			coil_b_mag_o <= direct_b_mag_ff;
			coil_b_neg_o <= direct_b_neg_ff;
		end else begin
			coil_a_mag_o <= sine_val[7:0];
			coil_a_neg_o <= sine_val[8];
			coil_b_mag_o <= cosine_val[7:0];
			coil_b_neg_o <= cosine_val[8];
		end
	end

	// mode and position outputs
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			chop_mode_o   <= 1'b0;
			step_dir_en_o <= 1'b1;
			ustep_count_o <= 10'h000;
		end else begin
			chop_mode_o   <= chop_mode_ff;
			step_dir_en_o <= ~step_dir_dis_ff;
			ustep_count_o <= ustep_ff;
		end
	end

	// ------------------------------------------------------------
	// status word
	// ------------------------------------------------------------

	// frozen while a frame runs so the shifted word stays consistent
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			status_ff <= 20'h00000;
		end else if (csn_sync2_ff) begin
			status_ff <= {ustep_ff, mres_ff, step_both_edges_sel_ff,
				step_dir_dis_ff, chop_mode_ff, 3'h0};
		end
	end

	assign link_bus.status_word = status_ff;

endmodule : step_dir_microstep_control

// [tb/step_dir_chk.sv]
// port assertions for the step/direction microstep control block
module step_dir_chk (
	input wire logic       core_clk_i,
	input wire logic       rstn_i,
	input wire logic       spi_sck_i,
	input wire logic       spi_csn_i,
	input wire logic       spi_sdi_i,
	input wire logic       spi_sdo_o,
	input wire logic       spi_sdo_oe_o,
	input wire logic       step_i,
	input wire logic       dir_i,
	input wire logic [7:0] coil_a_mag_o,
	input wire logic       coil_a_neg_o,
	input wire logic [7:0] coil_b_mag_o,
	input wire logic       coil_b_neg_o,
	input wire logic       chop_mode_o,
	input wire logic       step_dir_en_o,
	input wire logic [9:0] ustep_count_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       step_q_ff;
	logic [5:0] since_ff;
	// cycles since the step pin last moved, saturating
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			step_q_ff <= 1'b0;
			since_ff  <= 6'h3f;
		end else begin
			step_q_ff <= step_i;
			if (step_q_ff != step_i)
				since_ff <= 6'h00;
			else if (since_ff != 6'h3f)
				since_ff <= since_ff + 6'h01;
		end
	end
	a_reset_vals: assert property (
		@(posedge core_clk_i) !rstn_i ##1 !rstn_i |-> step_dir_en_o
		&& ustep_count_o == 10'h000 && coil_a_mag_o == 8'h00 && !spi_sdo_oe_o)
		else $error("reset values wrong");
	a_frozen_off: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(!step_dir_en_o)[*3] |-> $stable(ustep_count_o))
		else $error("counter moved while step path off");
	a_step_pow2: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		$changed(ustep_count_o) |-> $onehot(10'(ustep_count_o - $past(ustep_count_o)))
		|| $onehot(10'($past(ustep_count_o) - ustep_count_o)))
		else $error("step size not a power of two");
	a_step_delay: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		$changed(ustep_count_o) |-> since_ff >= 6'h0a && since_ff <= 6'h18)
		else $error("counter moved without a filtered step");
	a_sdo_idle: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		spi_csn_i ##1 spi_csn_i |-> !spi_sdo_oe_o && !spi_sdo_o)
		else $error("serial output driven outside a frame");
	a_oe_frame: assert property (
		@(posedge spi_sck_i) disable iff (!rstn_i)
		!spi_csn_i |-> spi_sdo_oe_o)
		else $error("no bit returned in frame");
	a_table_zero: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(step_dir_en_o && ustep_count_o == 10'h000)[*4] |-> coil_a_mag_o == 8'h00
		&& coil_b_mag_o == 8'hff && !coil_b_neg_o)
		else $error("coil values wrong at counter zero");
	a_chop_serial: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		$changed(chop_mode_o) |-> !$past(spi_csn_i, 8))
		else $error("chopper mode changed without a frame");
	a_en_serial: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		$changed(step_dir_en_o) |-> !$past(spi_csn_i, 8))
		else $error("step enable changed without a frame");
endmodule : step_dir_chk

bind step_dir_microstep_control step_dir_chk u_chk (
	.core_clk_i(core_clk_i), .rstn_i(rstn_i), .spi_sck_i(spi_sck_i),
	.spi_csn_i(spi_csn_i), .spi_sdi_i(spi_sdi_i), .spi_sdo_o(spi_sdo_o),
	.spi_sdo_oe_o(spi_sdo_oe_o), .step_i(step_i), .dir_i(dir_i),
	.coil_a_mag_o(coil_a_mag_o), .coil_a_neg_o(coil_a_neg_o),
	.coil_b_mag_o(coil_b_mag_o), .coil_b_neg_o(coil_b_neg_o),
	.chop_mode_o(chop_mode_o), .step_dir_en_o(step_dir_en_o),
	.ustep_count_o(ustep_count_o)
);

// [tb/spi_master_model.sv]
// serial master model: one command word out, one status word back
module spi_master_model (
	output logic      sck_o,
	output logic      csn_o,
	output logic      sdi_o,
	input  wire logic sdo_i,
	input  wire logic sdo_oe_i
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle: clock high and still, deselected; set just after time zero so the
	// slave's frame counters are sure to see a real rising chip select
	initial begin
		#1;
		csn_o = 1'b1;
		sck_o = 1'b1;
		sdi_o = 1'b0;
	end
	// one frame of n bits, msb first; an undriven return bit reads inverted
	task automatic xfer(input step_dir_pkg::word_t cmd, input int n,
		output step_dir_pkg::word_t rsp);
		rsp = '0;
		csn_o = 1'b0;
		#24;
		for (int i = 0; i < n; i++) begin
			sck_o = 1'b0;
			sdi_o = cmd[19 - i];
			#24;
			sck_o = 1'b1;
			rsp = {rsp[18:0], sdo_oe_i ? sdo_i : ~sdo_i};
			#24;
		end
		csn_o = 1'b1;
		sdi_o = ~sdi_o;
		#48;
	endtask : xfer
endmodule : spi_master_model

// [tb/tb_step_dir_microstep_control.sv]
// self-checking bench for the step/direction microstep control block
module tb_step_dir_microstep_control;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {
		logic [3:0] mres;
		logic       both;
		logic       dir;
		logic [9:0] cnt;
	} row_s;
	logic                clk;
	logic                rstn;
	logic                sck;
	logic                csn;
	logic                sdi;
	logic                sdo;
	logic                sdo_oe;
	logic                step;
	logic                dir;
	logic [7:0]          a_mag;
	logic                a_neg;
	logic [7:0]          b_mag;
	logic                b_neg;
	logic                chop;
	logic                en;
	logic [9:0]          cnt;
	int                  err_count;
	int                  checks_done;
	step_dir_pkg::word_t rsp;
	// resolution, edge mode, direction, expected counter after one row
	row_s rows [11] = '{'{4'h0, 1'b0, 1'b0, 10'h001}, '{4'h1, 1'b0, 1'b0, 10'h003},
		'{4'h2, 1'b0, 1'b1, 10'h3ff}, '{4'h3, 1'b0, 1'b0, 10'h007},
		'{4'h4, 1'b0, 1'b1, 10'h3f7}, '{4'h5, 1'b0, 1'b0, 10'h017},
		'{4'h6, 1'b0, 1'b0, 10'h057}, '{4'h7, 1'b0, 1'b1, 10'h3d7},
		'{4'h8, 1'b0, 1'b0, 10'h0d7}, '{4'h8, 1'b1, 1'b1, 10'h2d7},
		'{4'h9, 1'b0, 1'b0, 10'h3d7}};
	step_dir_microstep_control dut (
		.core_clk_i(clk), .rstn_i(rstn), .spi_sck_i(sck), .spi_csn_i(csn),
		.spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe), .step_i(step),
		.dir_i(dir), .coil_a_mag_o(a_mag), .coil_a_neg_o(a_neg),
		.coil_b_mag_o(b_mag), .coil_b_neg_o(b_neg), .chop_mode_o(chop),
		.step_dir_en_o(en), .ustep_count_o(cnt));
	spi_master_model mst (.sck_o(sck), .csn_o(csn), .sdi_o(sdi), .sdo_i(sdo),
		.sdo_oe_i(sdo_oe));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	always #2.5 clk = ~clk;
	task automatic expect_eq(input logic [19:0] got, input logic [19:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : expect_eq
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_cyc
	// each pin edge is held well past the filter
	task automatic toggle_step(input int n);
		repeat (n) begin
			step = ~step;
			wait_cyc(30);
		end
	endtask : toggle_step
	task automatic send(input step_dir_pkg::word_t w);
		mst.xfer(w, 20, rsp);
		wait_cyc(4);
	endtask : send
	function automatic step_dir_pkg::word_t cfg(input logic [3:0] m, input logic c, d, b);
		return {12'h000, m, 1'b0, c, d, b};
	endfunction : cfg
	task automatic print_verdict();
		if (err_count == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		step = 1'b0;
		dir = 1'b0;
		err_count = 0;
		checks_done = 0;
		wait_cyc(8);
		rstn = 1'b1;
		wait_cyc(4);
		// every resolution, both edge modes, wrap both ways
		foreach (rows[i]) begin
			send(cfg(rows[i].mres, 1'b0, 1'b0, rows[i].both));
			dir = rows[i].dir;
			wait_cyc(30);
			toggle_step(2);
			expect_eq(20'(cnt), 20'(rows[i].cnt));
			mst.xfer({2'b11, 18'h00000}, 20, rsp);
			expect_eq(rsp, {rows[i].cnt, (rows[i].mres > 4'h8) ? 4'h8 : rows[i].mres,
				rows[i].both, 5'h00});
		end
		// second reset in mid-run, launched on a falling edge
		wait_cyc(1);
		rstn = 1'b0;
		wait_cyc(8);
		expect_eq({cnt, a_mag, chop, en}, {10'h000, 8'h00, 1'b0, 1'b1});
		rstn = 1'b1;
		wait_cyc(4);
		// a pulse shorter than the filter must not step
		step = 1'b1;
		wait_cyc(5);
		step = 1'b0;
		wait_cyc(30);
		expect_eq(20'(cnt), 20'h00000);
		expect_eq({a_mag, b_mag, a_neg, b_neg, 2'b00}, 20'h00ff0);
		// direct coil writes with the step path off
		send(cfg(4'h0, 1'b1, 1'b1, 1'b0));
		send({2'b01, 9'h000, 1'b1, 8'h5a});
		send({2'b10, 9'h000, 1'b0, 8'hc3});
		wait_cyc(2);
		expect_eq({a_mag, a_neg, b_mag, b_neg, en, chop}, {8'h5a, 1'b1, 8'hc3, 3'b001});
		toggle_step(2);
		expect_eq({cnt, a_mag, 2'b00}, {10'h000, 8'h5a, 2'b00});
		// a cut-short frame is dropped
		mst.xfer(cfg(4'h0, 1'b0, 1'b0, 1'b0), 12, rsp);
		mst.xfer({2'b11, 18'h00000}, 20, rsp);
		expect_eq(rsp, 20'h00018);
		// back to stepping in the other chopper mode, full steps
		send(cfg(4'h8, 1'b0, 1'b0, 1'b0));
		toggle_step(2);
		expect_eq({cnt, a_mag, en, chop}, {10'h100, 8'hff, 1'b1, 1'b0});
		print_verdict();
	end
	// hang guard, well beyond the expected run length
	initial begin
		#200us;
		err_count++;
		print_verdict();
	end
endmodule : tb_step_dir_microstep_control
